// *** src/cal_cfg_pkg.sv ***
// Purpose: Shared constants and carriers for the calibration and configuration register bank
// Assumes: 24-bit registers, 5-bit register index, pages selected through index 31 on any page
// Notes: Page 1 and page 3 registers have no defined reset value and are cleared to zero
package cal_cfg_pkg;
   localparam int REG_W = 24;
   localparam int IDX_W = 5;
   localparam int PAGE_W = 6;
   localparam int SUM_W = 48;
   localparam int NUM_W = 72;

   // Page 0 register indexes
   localparam logic [IDX_W-1:0] SETUP_CONTROL_IDX = 5'h00;
   localparam logic [IDX_W-1:0] CURRENT_DC_BIAS_IDX = 5'h01;
   localparam logic [IDX_W-1:0] CURRENT_SCALE_FACTOR_IDX = 5'h02;
   localparam logic [IDX_W-1:0] VOLTAGE_DC_BIAS_IDX = 5'h03;
   localparam logic [IDX_W-1:0] VOLTAGE_SCALE_FACTOR_IDX = 5'h04;
   localparam logic [IDX_W-1:0] CYCLE_COUNT_IDX = 5'h05;
   localparam logic [IDX_W-1:0] CURRENT_AC_BIAS_IDX = 5'h10;
   localparam logic [IDX_W-1:0] VOLTAGE_AC_BIAS_IDX = 5'h11;
   localparam logic [IDX_W-1:0] PAGE_SELECT_IDX = 5'h1f;
   // Page 1 register indexes
   localparam logic [IDX_W-1:0] ENERGY_OUTPUT_DURATION_IDX = 5'h00;
   localparam logic [IDX_W-1:0] NO_LOAD_THRESHOLD_IDX = 5'h01;
   localparam logic [IDX_W-1:0] THERMAL_SENSOR_SCALE_IDX = 5'h02;
   localparam logic [IDX_W-1:0] THERMAL_SENSOR_BIAS_IDX = 5'h03;
   // Page 3 register indexes
   localparam logic [IDX_W-1:0] VOLTAGE_DIP_WINDOW_IDX = 5'h06;
   localparam logic [IDX_W-1:0] VOLTAGE_DIP_THRESHOLD_IDX = 5'h07;
   localparam logic [IDX_W-1:0] CURRENT_FAULT_WINDOW_IDX = 5'h0a;
   localparam logic [IDX_W-1:0] CURRENT_FAULT_THRESHOLD_IDX = 5'h0b;

   localparam logic [PAGE_W-1:0] PAGE_ZERO = 6'h00;
   localparam logic [PAGE_W-1:0] PAGE_ONE = 6'h01;
   localparam logic [PAGE_W-1:0] PAGE_THREE = 6'h03;

   // Reset values
   localparam logic [REG_W-1:0] SETUP_CONTROL_RST = 24'h000001;
   localparam logic [REG_W-1:0] DC_BIAS_RST = 24'h000000;
   localparam logic [REG_W-1:0] SCALE_FACTOR_RST = 24'h400000;
   localparam logic [REG_W-1:0] CYCLE_COUNT_RST = 24'h000fa0;
   localparam logic [REG_W-1:0] PAGE_REG_RST = 24'h000000;

   // Setup register fields
   localparam int PHASE_MSB = 23;
   localparam int PHASE_LSB = 17;
   localparam int CUR_GAIN_BIT = 16;
   localparam int OPEN_DRAIN_BIT = 15;
   localparam int IRQ_PULSE_BIT = 12;
   localparam int IRQ_INV_BIT = 11;
   localparam int PROC_CLK_INV_BIT = 4;
   localparam int K_MSB = 3;

   // Command byte layout
   localparam logic [2:0] CAL_CMD_PREFIX = 3'b110;
   localparam int RW_BIT = 6;

   // Calibration selector fields: [4:3] channel, [2] AC, [1:0] kind
   localparam logic [1:0] CAL_KIND_OFFSET = 2'b01;
   localparam logic [1:0] CAL_KIND_GAIN = 2'b10;
   localparam logic [1:0] CAL_CH_NONE = 2'b00;

   // Gain calibration drives the measured level to this full-scale target
   localparam logic [REG_W-1:0] GAIN_TARGET = 24'h600000;
   localparam int GAIN_FRAC_BITS = 22;

   // Interrupt pulse length in cycles
   localparam int IRQ_PULSE_CYCLES = 8;

   typedef struct packed {
      logic valid;
      logic [7:0] op;
      logic [REG_W-1:0] wdata;
   } host_cmd_t;

   typedef struct packed {
      logic valid;
      logic [REG_W-1:0] data;
   } read_reply_t;

   typedef struct packed {
      logic valid;
      logic signed [REG_W-1:0] current;
      logic signed [REG_W-1:0] voltage;
   } conversion_t;

   // Code 0 stands for a divisor of 16
   function automatic logic [4:0] k_from_code(input logic [3:0] code);
      k_from_code = (code == 4'h0) ? 5'h10 : {1'b0, code};
   endfunction

   function automatic logic cal_sel_valid(input logic [4:0] sel);
      cal_sel_valid = (sel[4:3] != CAL_CH_NONE)
         && (sel[1:0] == CAL_KIND_OFFSET || sel[1:0] == CAL_KIND_GAIN);
   endfunction

   function automatic logic [REG_W-1:0] magnitude(input logic [REG_W-1:0] v);
      magnitude = v[REG_W-1] ? REG_W'(-v) : v;
   endfunction
endpackage

// *** src/div_clock_gen.sv ***
// Purpose: Derive the internal divided clock from the master clock by divisor K
// Assumes: K code 0 means 16
// Notes: Output is a registered square wave toggling once every K master cycles
`timescale 1ns/1ps
module div_clock_gen
   import cal_cfg_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic [3:0] i_k_code,
   output logic o_tick,
   output logic o_level
);
   logic [4:0] count;

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         count <= 5'h00;
         o_tick <= 1'b0;
      end else if (count + 5'h01 >= k_from_code(i_k_code)) begin
         count <= 5'h00;
         o_tick <= 1'b1;
      end else begin
         count <= count + 5'h01;
         o_tick <= 1'b0;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_level <= 1'b0;
      end else if (o_tick) begin
         o_level <= ~o_level;
      end
   end
endmodule // div_clock_gen

// *** src/cal_divider.sv ***
// Purpose: Unsigned restoring divider for calibration results
// Assumes: One quotient bit per cycle, NW cycles per division
// Notes: Divide by zero yields an all-ones quotient, which the caller saturates
`timescale 1ns/1ps
module cal_divider #(
   parameter int NW = 72,
   parameter int DW = 48
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_start,
   input wire logic [NW-1:0] i_num,
   input wire logic [DW-1:0] i_den,
   output logic o_done,
   output logic [NW-1:0] o_quo
);
   logic [DW:0] rem;
   logic [NW-1:0] shreg;
   logic [DW-1:0] den;
   logic [7:0] bits_left;
   logic [DW:0] trial;

   assign trial = {rem[DW-1:0], shreg[NW-1]};

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         rem <= '0;
         shreg <= '0;
         den <= '0;
         bits_left <= 8'h00;
         o_done <= 1'b0;
         o_quo <= '0;
      end else if (i_start) begin
         rem <= '0;
         shreg <= i_num;
         den <= i_den;
         bits_left <= 8'(NW);
         o_done <= 1'b0;
      end else if (bits_left != 8'h00) begin
         if (trial >= {1'b0, den}) begin
            rem <= trial - {1'b0, den};
            shreg <= {shreg[NW-2:0], 1'b1};
         end else begin
            rem <= trial;
            shreg <= {shreg[NW-2:0], 1'b0};
         end
         bits_left <= bits_left - 8'h01;
         o_done <= (bits_left == 8'h01);
         if (bits_left == 8'h01) begin
            o_quo <= {shreg[NW-2:0], trial >= {1'b0, den}};
         end
      end else begin
         o_done <= 1'b0;
      end
   end
endmodule // cal_divider

// *** src/calibration_config_regs.sv ***
// Purpose: Calibration command decoder and setup, offset, gain and paged settings registers
// Assumes: A serial framer presents each command byte, and write data after the 24th clock
// Notes: Pulse generator, status and mask logic sit outside and use the outputs here
`timescale 1ns/1ps
module calibration_config_regs
(
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire cal_cfg_pkg::host_cmd_t i_cmd,
   input wire cal_cfg_pkg::conversion_t i_conv,
   input wire logic i_irq_request,
   input wire logic i_pulse_one,
   input wire logic i_pulse_two,
   input wire logic i_data_ready_clear,
   output cal_cfg_pkg::read_reply_t o_reply,
   output logic o_data_ready_flag,
   output logic o_cal_busy,
   output logic [6:0] o_phase_delay_comp,
   output logic o_current_gain_high,
   output logic o_energy_pulse_out_one_n,
   output logic o_energy_pulse_out_one_oe,
   output logic o_energy_pulse_out_two_n,
   output logic o_energy_pulse_out_two_oe,
   output logic o_irq_pin,
   output logic o_internal_divided_clock,
   output logic o_processor_clock_output
);
   import cal_cfg_pkg::*;
   typedef enum logic [2:0] {
      CAL_IDLE = 3'b000,
      CAL_ACCUM = 3'b001,
      CAL_DIV = 3'b010,
      CAL_WAIT = 3'b011,
      CAL_DONE = 3'b100
   } cal_state_t;
   cal_state_t state;
   logic [REG_W-1:0] setup_control, current_dc_bias, current_scale_factor, voltage_dc_bias;
   logic [REG_W-1:0] voltage_scale_factor, current_ac_bias, voltage_ac_bias, cycle_count;
   logic [REG_W-1:0] conv_seen, cycle_n, result;
   logic [REG_W-1:0] page1_regs [4], page3_regs [4];
   logic [PAGE_W-1:0] page;
   logic [IDX_W-1:0] cmd_idx;
   logic [4:0] cal_sel;
   logic [3:0] irq_count;
   logic [1:0] page3_slot;
   logic signed [SUM_W-1:0] sum_cur, sum_volt;
   logic [SUM_W-1:0] div_den, sum_mag;
   logic [NUM_W-1:0] div_quo, div_num;
   logic chan, div_start, div_done, sum_neg, wr_en, rd_en, cal_cmd, page3_hit;
   logic div_level, irq_req_q;
   assign cmd_idx = i_cmd.op[5:1];
   assign wr_en = i_cmd.valid && !i_cmd.op[7] && !i_cmd.op[0] && i_cmd.op[RW_BIT];
   assign rd_en = i_cmd.valid && !i_cmd.op[7] && !i_cmd.op[0] && !i_cmd.op[RW_BIT];
   assign cal_cmd = i_cmd.valid && i_cmd.op[7:5] == CAL_CMD_PREFIX;
   always_comb begin
      page3_hit = 1'b1;
      page3_slot = 2'd0;
      case (cmd_idx)
         VOLTAGE_DIP_WINDOW_IDX: page3_slot = 2'd0;
         VOLTAGE_DIP_THRESHOLD_IDX: page3_slot = 2'd1;
         CURRENT_FAULT_WINDOW_IDX: page3_slot = 2'd2;
         CURRENT_FAULT_THRESHOLD_IDX: page3_slot = 2'd3;
         default: page3_hit = 1'b0;
      endcase
   end
   // Setup, cycle count and page select; undefined indexes are ignored
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         setup_control <= SETUP_CONTROL_RST;
         cycle_count <= CYCLE_COUNT_RST;
         page <= PAGE_ZERO;
      end else if (wr_en && page == PAGE_ZERO) begin
         if (cmd_idx == SETUP_CONTROL_IDX) setup_control <= i_cmd.wdata;
         if (cmd_idx == CYCLE_COUNT_IDX) cycle_count <= i_cmd.wdata;
      end
      if (i_rst_n && wr_en && cmd_idx == PAGE_SELECT_IDX) page <= i_cmd.wdata[PAGE_W-1:0];
   end
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         for (int i = 0; i < 4; i++) begin
            page1_regs[i] <= PAGE_REG_RST;
            page3_regs[i] <= PAGE_REG_RST;
         end
      end else if (wr_en) begin
         if (page == PAGE_ONE && cmd_idx <= THERMAL_SENSOR_BIAS_IDX) begin
            page1_regs[cmd_idx[1:0]] <= i_cmd.wdata;
         end
         if (page == PAGE_THREE && page3_hit) begin
            page3_regs[page3_slot] <= i_cmd.wdata;
         end
      end
   end
   // Calibration results; a result landing with a host write takes precedence
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         current_dc_bias <= DC_BIAS_RST;
         voltage_dc_bias <= DC_BIAS_RST;
         current_scale_factor <= SCALE_FACTOR_RST;
         voltage_scale_factor <= SCALE_FACTOR_RST;
         current_ac_bias <= DC_BIAS_RST;
         voltage_ac_bias <= DC_BIAS_RST;
      end else if (state == CAL_WAIT && div_done) begin
         case ({chan, cal_sel[2], cal_sel[1:0] == CAL_KIND_GAIN})
            3'b000: current_dc_bias <= result;
            3'b010: current_ac_bias <= result;
            3'b001, 3'b011: current_scale_factor <= result;
            3'b100: voltage_dc_bias <= result;
            3'b110: voltage_ac_bias <= result;
            3'b101, 3'b111: voltage_scale_factor <= result;
            default: current_dc_bias <= current_dc_bias;
         endcase
      end else if (wr_en && page == PAGE_ZERO) begin
         case (cmd_idx)
            CURRENT_DC_BIAS_IDX: current_dc_bias <= i_cmd.wdata;
            CURRENT_SCALE_FACTOR_IDX: current_scale_factor <= i_cmd.wdata;
            VOLTAGE_DC_BIAS_IDX: voltage_dc_bias <= i_cmd.wdata;
            VOLTAGE_SCALE_FACTOR_IDX: voltage_scale_factor <= i_cmd.wdata;
            CURRENT_AC_BIAS_IDX: current_ac_bias <= i_cmd.wdata;
            VOLTAGE_AC_BIAS_IDX: voltage_ac_bias <= i_cmd.wdata;
            default: current_dc_bias <= current_dc_bias;
         endcase
      end
   end
   // Read answer one cycle after the read command; unmapped reads return zero
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_reply <= '0;
      end else begin
         o_reply.valid <= rd_en;
         o_reply.data <= '0;
         if (rd_en && page == PAGE_ZERO) begin
            case (cmd_idx)
               SETUP_CONTROL_IDX: o_reply.data <= setup_control;
               CURRENT_DC_BIAS_IDX: o_reply.data <= current_dc_bias;
               CURRENT_SCALE_FACTOR_IDX: o_reply.data <= current_scale_factor;
               VOLTAGE_DC_BIAS_IDX: o_reply.data <= voltage_dc_bias;
               VOLTAGE_SCALE_FACTOR_IDX: o_reply.data <= voltage_scale_factor;
               CYCLE_COUNT_IDX: o_reply.data <= cycle_count;
               CURRENT_AC_BIAS_IDX: o_reply.data <= current_ac_bias;
               VOLTAGE_AC_BIAS_IDX: o_reply.data <= voltage_ac_bias;
               PAGE_SELECT_IDX: o_reply.data <= REG_W'(page);
               default: o_reply.data <= '0;
            endcase
         end else if (rd_en && page == PAGE_ONE && cmd_idx <= THERMAL_SENSOR_BIAS_IDX) begin
            o_reply.data <= page1_regs[cmd_idx[1:0]];
         end else if (rd_en && page == PAGE_THREE && page3_hit) begin
            o_reply.data <= page3_regs[page3_slot];
         end else if (rd_en && cmd_idx == PAGE_SELECT_IDX) begin
            o_reply.data <= REG_W'(page);
         end
      end
   end
   // Measurement engine: one computation cycle, then divide per selected channel
   assign sum_neg = chan ? sum_volt[SUM_W-1] : sum_cur[SUM_W-1];
   assign sum_mag = sum_neg ? SUM_W'(-(chan ? sum_volt : sum_cur)) : (chan ? sum_volt : sum_cur);
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         state <= CAL_IDLE;
         cal_sel <= 5'h00;
         conv_seen <= '0;
         cycle_n <= CYCLE_COUNT_RST;
         sum_cur <= '0;
         sum_volt <= '0;
         chan <= 1'b0;
         div_start <= 1'b0;
         div_num <= '0;
         div_den <= '0;
      end else begin
         div_start <= 1'b0;
         case (state)
            CAL_IDLE: begin
               // Undefined selectors are dropped rather than run
               if (cal_cmd && cal_sel_valid(i_cmd.op[4:0])) begin
                  cal_sel <= i_cmd.op[4:0];
                  cycle_n <= (cycle_count == '0) ? REG_W'(1) : cycle_count;
                  conv_seen <= '0;
                  sum_cur <= '0;
                  sum_volt <= '0;
                  state <= CAL_ACCUM;
               end
            end
            CAL_ACCUM: begin
               if (i_conv.valid) begin
                  if (cal_sel[2] || cal_sel[1:0] == CAL_KIND_GAIN) begin
                     sum_cur <= sum_cur + SUM_W'(magnitude(i_conv.current));
                     sum_volt <= sum_volt + SUM_W'(magnitude(i_conv.voltage));
                  end else begin
                     sum_cur <= sum_cur + SUM_W'(i_conv.current);
                     sum_volt <= sum_volt + SUM_W'(i_conv.voltage);
                  end
                  conv_seen <= conv_seen + REG_W'(1);
                  if (conv_seen + REG_W'(1) >= cycle_n) begin
                     chan <= !cal_sel[3];
                     state <= CAL_DIV;
                  end
               end
            end
            CAL_DIV: begin
               div_start <= 1'b1;
               if (cal_sel[1:0] == CAL_KIND_GAIN) begin
                  div_num <= (NUM_W'(GAIN_TARGET) * NUM_W'(cycle_n)) << GAIN_FRAC_BITS;
                  div_den <= sum_mag;
               end else begin
                  div_num <= NUM_W'(sum_mag);
                  div_den <= SUM_W'(cycle_n);
               end
               state <= CAL_WAIT;
            end
            CAL_WAIT: begin
               if (div_done) begin
                  if (!chan && cal_sel[4]) begin
                     chan <= 1'b1;
                     state <= CAL_DIV;
                  end else begin
                     state <= CAL_DONE;
                  end
               end
            end
            CAL_DONE: state <= CAL_IDLE;
            default: state <= CAL_IDLE;
         endcase
      end
   end
   always_comb begin
      if (cal_sel[1:0] == CAL_KIND_GAIN) begin
         result = (div_quo > NUM_W'(24'hffffff)) ? 24'hffffff : div_quo[REG_W-1:0];
      end else begin
         result = sum_neg ? REG_W'(-div_quo[REG_W-1:0]) : div_quo[REG_W-1:0];
      end
   end
   cal_divider #(
      .NW(NUM_W),
      .DW(SUM_W)
   ) u_divider (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_start(div_start),
      .i_num(div_num),
      .i_den(div_den),
      .o_done(div_done),
      .o_quo(div_quo)
   );
   // Set wins over a clear arriving in the same cycle
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_data_ready_flag <= 1'b0;
         o_cal_busy <= 1'b0;
      end else begin
         o_cal_busy <= (state != CAL_IDLE) || (cal_cmd && cal_sel_valid(i_cmd.op[4:0]));
         if (state == CAL_DONE) begin
            o_data_ready_flag <= 1'b1;
         end else if (i_data_ready_clear) begin
            o_data_ready_flag <= 1'b0;
         end
      end
   end
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_phase_delay_comp <= 7'h00;
         o_current_gain_high <= 1'b0;
         o_energy_pulse_out_one_n <= 1'b1;
         o_energy_pulse_out_one_oe <= 1'b1;
         o_energy_pulse_out_two_n <= 1'b1;
         o_energy_pulse_out_two_oe <= 1'b1;
      end else begin
         o_phase_delay_comp <= setup_control[PHASE_MSB:PHASE_LSB];
         o_current_gain_high <= setup_control[CUR_GAIN_BIT];
         o_energy_pulse_out_one_n <= ~i_pulse_one;
         o_energy_pulse_out_two_n <= ~i_pulse_two;
         // Open-drain mode only drives while pulling low
         o_energy_pulse_out_one_oe <= !setup_control[OPEN_DRAIN_BIT] || i_pulse_one;
         o_energy_pulse_out_two_oe <= !setup_control[OPEN_DRAIN_BIT] || i_pulse_two;
      end
   end
   // Interrupt pin shaping: level modes follow the request, pulse modes fire on its rise
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         irq_req_q <= 1'b0;
         irq_count <= 4'h0;
         o_irq_pin <= 1'b1;
      end else begin
         irq_req_q <= i_irq_request;
         if (i_irq_request && !irq_req_q) begin
            irq_count <= 4'(IRQ_PULSE_CYCLES);
         end else if (irq_count != 4'h0) begin
            irq_count <= irq_count - 4'h1;
         end
         case ({setup_control[IRQ_PULSE_BIT], setup_control[IRQ_INV_BIT]})
            2'b00: o_irq_pin <= !i_irq_request;
            2'b01: o_irq_pin <= i_irq_request;
            2'b10: o_irq_pin <= !(irq_count != 4'h0);
            2'b11: o_irq_pin <= (irq_count != 4'h0);
            default: o_irq_pin <= 1'b1;
         endcase
      end
   end
   div_clock_gen u_clock_gen (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_k_code(setup_control[K_MSB:0]),
      .o_tick(),
      .o_level(div_level)
   );
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_internal_divided_clock <= 1'b0;
         o_processor_clock_output <= 1'b0;
      end else begin
         o_internal_divided_clock <= div_level;
         o_processor_clock_output <= div_level ^ setup_control[PROC_CLK_INV_BIT];
      end
   end
endmodule // calibration_config_regs

// *** tb/cal_regs_checker.sv ***
// Purpose: Port assertions for the calibration and setup register bank
// Assumes: One clock, synchronous active-low reset
// Notes: Flag checks assume the clear input stays low during calibrations
`timescale 1ns/1ps
module cal_regs_checker
   import cal_cfg_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire cal_cfg_pkg::host_cmd_t i_cmd,
   input wire logic i_pulse_one,
   input wire logic i_data_ready_clear,
   input wire cal_cfg_pkg::read_reply_t o_reply,
   input wire logic o_data_ready_flag,
   input wire logic o_cal_busy,
   input wire logic o_energy_pulse_out_one_n
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   logic rd_cmd, wr_cmd, cal_ok;
   assign rd_cmd = i_cmd.valid && i_cmd.op[7:6] == 2'b00 && !i_cmd.op[0];
   assign wr_cmd = i_cmd.valid && i_cmd.op[7:6] == 2'b01 && !i_cmd.op[0];
   assign cal_ok = i_cmd.valid && i_cmd.op[7:5] == 3'b110 && i_cmd.op[4:3] != 2'b00
      && (i_cmd.op[1:0] == 2'b01 || i_cmd.op[1:0] == 2'b10);
   chk_read_answer: assert property (rd_cmd |=> o_reply.valid)
      else $error("read got no reply");
   chk_write_silent: assert property (wr_cmd |=> !o_reply.valid)
      else $error("write produced a reply");
   chk_reply_idle: assert property (!o_reply.valid |-> o_reply.data == 24'h000000)
      else $error("reply data not cleared");
   chk_cal_start: assert property (cal_ok && !o_cal_busy |=> o_cal_busy)
      else $error("calibration did not start");
   chk_done_flag: assert property ($fell(o_cal_busy) |-> o_data_ready_flag)
      else $error("no ready flag at calibration end");
   chk_flag_holds: assert property (o_data_ready_flag && !i_data_ready_clear |=> o_data_ready_flag)
      else $error("ready flag dropped");
   chk_flag_clear: assert property (i_data_ready_clear && !o_cal_busy |=> !o_data_ready_flag)
      else $error("ready flag not cleared");
   chk_pulse_pin: assert property ($past(i_rst_n) |-> o_energy_pulse_out_one_n == !$past(i_pulse_one))
      else $error("pulse pin wrong");
   cover property (cal_ok && !o_cal_busy);
   cover property ($rose(o_data_ready_flag));
   cover property (rd_cmd);
endmodule // cal_regs_checker
bind calibration_config_regs cal_regs_checker i_cal_regs_checker(.i_clk, .i_rst_n, .i_cmd,
   .i_pulse_one, .i_data_ready_clear, .o_reply, .o_data_ready_flag, .o_cal_busy,
   .o_energy_pulse_out_one_n);

// *** tb/host_model.sv ***
// Purpose: Host side of the command port, one command per call
// Assumes: Command taken at one edge, read reply standing the cycle after
// Notes: Released command lines show inverted values so stale data is not trusted
`timescale 1ns/1ps
module host_model
   import cal_cfg_pkg::*;
(
   input wire logic i_clk,
   input wire cal_cfg_pkg::read_reply_t i_reply,
   output cal_cfg_pkg::host_cmd_t o_cmd
);
   logic [23:0] last;
   initial o_cmd = '0;
   task automatic send(input logic [7:0] op, input logic [23:0] d);
      o_cmd = {1'b1, op, d};
      @(posedge i_clk);
      #1 o_cmd = {1'b0, ~op, ~d};
      last = i_reply.valid ? i_reply.data : 24'hxxxxxx;
      @(posedge i_clk);
      #1;
   endtask
   // Callers only write defined indexes, reserved bits zero
   task automatic wr(input logic [4:0] idx, input logic [23:0] d);
      send({2'b01, idx, 1'b0}, d);
   endtask
   task automatic rd(input logic [4:0] idx, output logic [23:0] d);
      send({2'b00, idx, 1'b0}, 24'h000000);
      d = last;
   endtask
   task automatic cal(input logic [4:0] sel);
      send({3'b110, sel}, 24'h000000);
   endtask
endmodule // host_model

// *** tb/test_calibration_config_regs.sv ***
// Purpose: Self-checking bench for the calibration and setup register bank
// Assumes: Host model issues commands; bench drives conversions and pins
// Notes: Cycle count cut to 4 and samples held constant so results are exact
`timescale 1ns/1ps
module test_calibration_config_regs;
   import cal_cfg_pkg::*;
   logic i_clk, i_rst_n, i_irq_request, i_pulse_one, i_data_ready_clear;
   host_cmd_t cmd;
   conversion_t i_conv;
   read_reply_t reply;
   logic data_ready_flag, busy, gain_hi, p1n, p1oe, p2n, p2oe, irq, internal_divided_clock, pclk, s, cr, gr, ar;
   logic [6:0] phase;
   logic [31:0] rng = 32'hc33f;
   logic [23:0] v, x, setup, mark;
   logic [23:0] vals [8];
   logic [4:0] k, sel;
   logic [4:0] pg_idx [8] = '{0, 1, 2, 3, 6, 7, 10, 11};
   logic [4:0] res_idx [6] = '{1, 2, 3, 4, 16, 17};
   logic [23:0] rst_val [6] = '{24'h000001, 0, 24'h400000, 0, 24'h400000, 24'h000fa0};
   int err_count, compares, cycles, n;
   host_model i_host_model(.i_clk, .i_reply(reply), .o_cmd(cmd));
   calibration_config_regs i_calibration_config_regs(.i_clk, .i_rst_n, .i_cmd(cmd), .i_conv,
      .i_irq_request, .i_pulse_one, .i_pulse_two(i_pulse_one), .i_data_ready_clear,
      .o_reply(reply), .o_data_ready_flag(data_ready_flag), .o_cal_busy(busy), .o_phase_delay_comp(phase),
      .o_current_gain_high(gain_hi), .o_energy_pulse_out_one_n(p1n),
      .o_energy_pulse_out_one_oe(p1oe), .o_energy_pulse_out_two_n(p2n),
      .o_energy_pulse_out_two_oe(p2oe), .o_irq_pin(irq), .o_internal_divided_clock(internal_divided_clock),
      .o_processor_clock_output(pclk));
   function automatic logic [23:0] rnd();
      rng ^= rng << 13;
      rng ^= rng >> 17;
      rng ^= rng << 5;
      return rng[23:0];
   endfunction
   // Constant samples make the mean equal to the sample
   function automatic logic [23:0] cal_exp(input logic [23:0] smp, input logic g, input logic a);
      logic [23:0] m;
      m = smp[23] ? -smp : smp;
      if (g) return 24'((48'h600000 << 22) / {24'h000000, m});
      return a ? m : smp;
   endfunction
   task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
      compares++;
      if (seen !== exp) begin
         err_count++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic cyc(input int c);
      repeat (c) @(posedge i_clk);
      #1;
   endtask
   task automatic stop_test();
      $display("compares %0d err_count %0d", compares, err_count);
      if (err_count == 0 && compares > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   initial begin
      i_clk = 0;
      forever #2 i_clk = ~i_clk;
   end
   initial begin
      cycles = 0;
      forever begin
         @(posedge i_clk);
         cycles++;
         if (cycles > 20000) begin
            err_count++;
            stop_test();
         end
      end
   end
   initial begin
      {i_rst_n, i_irq_request, i_pulse_one, i_data_ready_clear} = 4'h0;
      i_conv = {1'b0, 24'h200000, 24'hd00000};
      repeat (8) @(posedge i_clk);
      #1 i_rst_n = 1;
      for (int j = 0; j < 6; j++) begin
         i_host_model.rd(5'(j), v);
         chk(v, rst_val[j]);
      end
      for (int m = 0; m < 4; m++) begin
         v = rnd();
         setup = {v[23:15], 2'b00, 2'(m), 6'h00, v[4:0]};
         i_host_model.wr(0, setup);
         i_host_model.rd(0, v);
         chk(v, setup);
         chk(24'(phase), 24'(setup[23:17]));
         chk(24'(gain_hi), 24'(setup[16]));
         for (int p = 0; p < 2; p++) begin
            i_pulse_one = p[0];
            cyc(2);
            chk(24'({p1oe, p2oe, p1n, p2n}), 24'({{2{!setup[15] || p[0]}}, {2{!p[0]}}}));
         end
         cyc(12);
         chk(24'(irq), 24'(!m[0]));
         i_irq_request = 1;
         cyc(4);
         chk(24'(irq), 24'(m[0]));
         i_irq_request = 0;
         k = (setup[3:0] == 4'h0) ? 5'h10 : {1'b0, setup[3:0]};
         for (int e = 0; e < 2; e++) begin
            s = internal_divided_clock;
            n = 0;
            while (internal_divided_clock === s && n < 40) begin
               cyc(1);
               n++;
            end
         end
         chk(24'(n), 24'(k));
         cyc(1);
         chk(24'(pclk), 24'(internal_divided_clock ^ setup[4]));
      end
      i_host_model.wr(0, 24'h000001);
      for (int j = 0; j < 8; j++) begin
         if (j % 4 == 0) i_host_model.wr(31, j < 4 ? 24'h000001 : 24'h000003);
         vals[j] = rnd();
         i_host_model.wr(pg_idx[j], vals[j]);
      end
      i_host_model.rd(8, v);
      chk(v, 24'h000000);
      for (int j = 0; j < 8; j++) begin
         if (j % 4 == 0) i_host_model.wr(31, j < 4 ? 24'h000001 : 24'h000003);
         i_host_model.rd(pg_idx[j], v);
         chk(v, vals[j]);
      end
      i_host_model.wr(31, 24'h000000);
      i_host_model.rd(0, v);
      chk(v, 24'h000001);
      i_host_model.wr(5, 24'h000004);
      for (int c = 4; c < 16; c++) begin
         sel = {c[3:2], c[1], c[0] ? 2'b10 : 2'b01};
         mark = rnd();
         for (int j = 0; j < 6; j++) i_host_model.wr(res_idx[j], mark);
         i_host_model.cal(sel);
         chk(24'(busy), 24'h000001);
         repeat (4) begin
            i_conv.valid = 1;
            cyc(1);
            i_conv.valid = 0;
            cyc(2);
         end
         n = 0;
         while (busy === 1'b1 && n < 400) begin
            cyc(1);
            n++;
         end
         chk(24'({busy, data_ready_flag}), 24'h000001);
         for (int j = 0; j < 6; j++) begin
            cr = (j < 4) ? (j < 2) : (j == 4);
            gr = (j < 4) && (j % 2 == 1);
            ar = (j >= 4);
            i_host_model.rd(res_idx[j], v);
            x = ((cr ? sel[3] : sel[4]) && (gr ? sel[1] : (sel[0] && sel[2] == ar)))
               ? cal_exp(cr ? 24'h200000 : 24'hd00000, gr, ar) : mark;
            chk(v, x);
         end
         i_data_ready_clear = 1;
         cyc(1);
         i_data_ready_clear = 0;
         cyc(1);
         chk(24'(data_ready_flag), 24'h000000);
      end
      stop_test();
   end
endmodule // test_calibration_config_regs
